// >>> test/hdlrx_link_receiver_checker.sv
`timescale 1ns/100ps
// ====================
// Bus and pin checks
module hdlrx_link_receiver_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq_pin_n,
  input wire logic        irq_pin_oe_n
);
  wire logic  req = hsel && hready && htrans[1];
  logic       wr_ic_q, wr_cf_q, rd_un_q, rd_st_q, rd_dt_q, en_q;
  logic [1:0] dis_q;

  // Data-phase flags, so checks can see what the data phase carried
  always_ff @(posedge clk) begin
    if (rst) begin
      {wr_ic_q, wr_cf_q, rd_un_q, rd_st_q, rd_dt_q, en_q} <= '0;
      dis_q <= 2'h0;
    end else begin
      wr_ic_q <= req && hwrite && haddr[7:0] == hdlrx_pkg::REG_INTCTL;
      wr_cf_q <= req && hwrite && haddr[7:0] == hdlrx_pkg::REG_CFG;
      rd_un_q <= req && !hwrite && haddr[7:0] > hdlrx_pkg::REG_ADDR;
      rd_st_q <= req && !hwrite && haddr[7:0] == hdlrx_pkg::REG_STATUS;
      rd_dt_q <= req && !hwrite && haddr[7:0] == hdlrx_pkg::REG_DATA;
      if (wr_cf_q) en_q <= hwdata[0];
      dis_q <= en_q ? 2'h0 : (dis_q == 2'h3 ? dis_q : dis_q + 2'h1);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  bus_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  zero_wait_a: assert property (!$past(rst) |-> hreadyout) else $error("wait state seen");
  reset_vals_a: assert property ($fell(rst) |-> irq_pin_n && irq_pin_oe_n && hrdata == 32'h0)
    else $error("outputs wrong after reset");
  oe_follow_a: assert property (wr_ic_q |-> ##2 irq_pin_oe_n == !$past(hwdata[7], 2))
    else $error("irq output enable wrong");
  unmapped_a: assert property (rd_un_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!(req && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  status_bits_a: assert property (rd_st_q |-> hrdata[31:9] == 23'h0)
    else $error("status upper bits set");
  data_bits_a: assert property (rd_dt_q |-> hrdata[31:8] == 24'h0)
    else $error("data upper bits set");
  dis_quiet_a: assert property (dis_q == 2'h3 |-> irq_pin_n)
    else $error("interrupt while disabled");

  cover property (rd_st_q ##1 hrdata[1]);
  cover property ($fell(irq_pin_n));
  cover property (rd_st_q ##1 hrdata[4]);
endmodule : hdlrx_link_receiver_checker

bind hdlrx_link_receiver hdlrx_link_receiver_checker chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_pin_n(irq_pin_n),
  .irq_pin_oe_n(irq_pin_oe_n));

// >>> test/hdlrx_link_receiver_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module hdlrx_link_receiver_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, lclk, ldat, irq_pin_n, irq_pin_oe_n;
  logic [31:0] hrdata, st;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  hdlrx_link_receiver uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link_clk_pin(lclk), .link_data_pin(ldat),
    .irq_pin_n(irq_pin_n), .irq_pin_oe_n(irq_pin_oe_n));
  hdlrx_link_src src (.clk(clk), .link_clk(lclk), .link_data(ldat));

  // ====================
  // Bus access and helpers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    st = hrdata;
    // Next address phase lands ten clocks after this one
    repeat (8) @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic pop(input logic [7:0] b, input logic [2:0] t);
    rd(hdlrx_pkg::REG_DATA);
    `CHK("data", {24'h0, b}, st)
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("tag", t, st[7:5])
  endtask : pop
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ hdlrx_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction : crc_upd

  // ====================
  // Scenarios
  task automatic t_reset;
    rd(hdlrx_pkg::REG_CFG);
    `CHK("cfg", 32'h0, st)
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("status", 32'h1, st)
    rd(8'h14);
    `CHK("unmapped", 32'h0, st)
    src.send(8'h7E, 1'b0);
    src.rel();
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("idle empty", 1'b1, st[0])
    $display("test reset done");
  endtask : t_reset
  task automatic t_linkup;
    wr(hdlrx_pkg::REG_INTCTL, 32'h82);
    wr(hdlrx_pkg::REG_CFG, 32'h1);
    src.send(8'h7E, 1'b0);
    src.rel();
    `CHK("irq pin", 1'b0, irq_pin_n)
    `CHK("irq oe", 1'b0, irq_pin_oe_n)
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("st", 9'h10C, st[8:0])
    pop(8'h00, hdlrx_pkg::TAG_LINKUP);
    `CHK("empty", 1'b1, st[0])
    repeat (2) @(posedge clk);
    `CHK("irq gone", 1'b1, irq_pin_n)
    $display("test linkup done");
  endtask : t_linkup
  task automatic t_frames;
    logic [15:0] c;
    logic [7:0]  q[$];
    for (int k = 0; k < 2; k++) begin
      q = '{8'h7E, 8'h3F};
      c = hdlrx_pkg::CRC_INIT;
      foreach (q[i]) c = crc_upd(c, q[i]);
      if (k == 0) begin
        q.push_back(~c[7:0]);
        q.push_back(~c[15:8]);
      end
      foreach (q[i]) src.send(q[i], 1'b1);
      src.send(8'h7E, 1'b0);
      src.rel();
      rd(hdlrx_pkg::REG_STATUS);
      `CHK("pkt set", 1'b1, st[1])
      rd(hdlrx_pkg::REG_STATUS);
      `CHK("pkt clear", 1'b0, st[1])
      foreach (q[i]) pop(q[i], (i == q.size() - 1) ? {1'b1, k[0], 1'b0} : 3'b000);
    end
    $display("test frames done");
  endtask : t_frames
  task automatic t_fill;
    repeat (4) src.send(8'hA5, 1'b1);
    src.rel();
    `CHK("fill irq", 1'b0, irq_pin_n)
    pop(8'hA5, hdlrx_pkg::TAG_DATA);
    repeat (2) @(posedge clk);
    `CHK("fill held", 1'b0, irq_pin_n)
    repeat (2) pop(8'hA5, hdlrx_pkg::TAG_DATA);
    repeat (2) @(posedge clk);
    `CHK("fill off", 1'b1, irq_pin_n)
    repeat (2) src.send(8'hFF, 1'b0);
    src.rel();
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("abort st", 2'b01, {st[8], st[2]})
    for (int n = 0; n < 4 && st[0] !== 1'b1; n++) begin
      rd(hdlrx_pkg::REG_DATA);
      rd(hdlrx_pkg::REG_STATUS);
    end
    `CHK("abort tag", hdlrx_pkg::TAG_ABORT, st[7:5])
    $display("test fill done");
  endtask : t_fill
  task automatic t_overrun;
    src.send(8'h7E, 1'b0);
    for (int i = 0; i < 130; i++) src.send(8'h00, 1'b1);
    src.rel();
    wr(hdlrx_pkg::REG_INTCTL, 32'h02);
    repeat (2) @(posedge clk);
    `CHK("oe off", 1'b1, irq_pin_oe_n)
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("overrun", 5'h1D, st[4:0])
    $display("test overrun done");
  endtask : t_overrun
  task automatic t_disable;
    wr(hdlrx_pkg::REG_INTCTL, 32'h82);
    repeat (2) src.send(8'hFF, 1'b0);
    src.rel();
    `CHK("irq on", 1'b0, irq_pin_n)
    wr(hdlrx_pkg::REG_CFG, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq off", 1'b1, irq_pin_n)
    rd(hdlrx_pkg::REG_STATUS);
    `CHK("pending", 1'b0, st[3])
    $display("test disable done");
  endtask : t_disable
  task automatic t_match;
    logic [15:0] c;
    pop(8'h00, hdlrx_pkg::TAG_ABORT);
    wr(hdlrx_pkg::REG_ADDR, 32'h00332211);
    rd(hdlrx_pkg::REG_ADDR);
    `CHK("addr", 32'h00332211, st)
    wr(hdlrx_pkg::REG_CFG, 32'h3);
    src.send(8'h7E, 1'b0);
    // First frame matches no address and must leave nothing behind
    for (int k = 0; k < 2; k++) begin
      src.send(k ? 8'h22 : 8'h44, 1'b1);
      src.send(8'h55, 1'b1);
      src.send(8'h7E, 1'b0);
    end
    src.rel();
    c = crc_upd(crc_upd(hdlrx_pkg::CRC_INIT, 8'h22), 8'h55);
    pop(8'h00, hdlrx_pkg::TAG_LINKUP);
    pop(8'h22, hdlrx_pkg::TAG_DATA);
    pop(8'h55, {1'b1, c != hdlrx_pkg::CRC_GOOD, 1'b0});
    `CHK("match empty", 1'b1, st[0])
    $display("test match done");
  endtask : t_match

  // ====================
  // Run control
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_linkup();
    t_frames();
    t_fill();
    t_overrun();
    t_disable();
    t_match();
    summarize();
  end
endmodule : hdlrx_link_receiver_tb_top

// >>> test/hdlrx_link_src.sv
`timescale 1ns/100ps
// ====================
// Serial source of the framer side
module hdlrx_link_src (
  input wire logic clk,
  output logic     link_clk,
  output logic     link_data
);
  int ones = 0;
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b1;
  end
  // Four cycles each side keeps the pin settled around the rise
  task automatic put_bit(input logic v);
    link_data <= v;
    repeat (4) @(posedge clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge clk);
    link_clk <= 1'b0;
  endtask : put_bit
  // Raw octets carry flags and aborts unstuffed
  task automatic send(input logic [7:0] b, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
    if (!stuff) ones = 0;
  endtask : send
  // Clock stands still between frames; the data pin wanders
  task automatic rel;
    repeat (8) @(posedge clk);
    link_data <= ~link_data;
  endtask : rel
endmodule : hdlrx_link_src

// >>> verilog/hdlrx_link_receiver.sv
`timescale 1ns/100ps

// Contract
// - Enable resets to zero, receiver disabled.
// - Interrupt pin undriven unless output enabled.
// - On enable assume idle, hunt flags.
// - First flag pushes link-up marker, interrupts.
// - Abort pushes link-down marker, interrupts.
// - Link change sets change-of-link-status bit.
// - Packet end sets packet bit; read clears.
// - Status after last byte shows end tag.
// - Fill above threshold interrupts until emptied.
// - Seven-bit threshold in interrupt control register.
// - Overrun sets flag, resets FIFO pointers.
// - Three-bit tag per FIFO byte.
// - Status holds FIFO-empty bit.
// - Interrupt pin is active-low inverse.
// - Pattern 01111110 is the flag.
// - Pattern 01111111 is an abort.
// - First serial bit is octet bit zero.
// - Compare addresses to first packet octet.
module hdlrx_link_receiver (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        link_clk_pin,
  input  wire logic        link_data_pin,
  output logic             irq_pin_n,
  output logic             irq_pin_oe_n
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = fb ? ((c >> 1) ^ hdlrx_pkg::CRC_POLY) : (c >> 1);
  endfunction : crc_step

  function automatic logic irq_of(input hdlrx_pkg::hdlrx_state_s s);
    irq_of = s.enable & (s.pkt | s.link_irq | s.fill_irq | s.fifo_overrun);
  endfunction : irq_of

  // ==========================================================================
  // State
  hdlrx_pkg::hdlrx_state_s st_q;
  hdlrx_pkg::hdlrx_state_s st_d;
  hdlrx_pkg::hdlrx_entry_s mem [hdlrx_pkg::FIFO_DEPTH];
  hdlrx_pkg::hdlrx_entry_s head;
  hdlrx_pkg::hdlrx_entry_s push_e;
  logic                    push;
  logic                    pop;
  logic                    wr_en;
  logic                    bit_ev;
  logic                    bit_v;
  logic                    do_shift;
  logic                    frame_rst;
  logic                    drop_n;
  logic                    mismatch;
  logic [7:0]              new_byte;
  logic [15:0]             crc_n;

  assign head = mem[st_q.rd_ptr];

  always_comb begin
    st_d      = st_q;
    push      = 1'b0;
    push_e    = '0;
    pop       = 1'b0;
    wr_en     = 1'b0;
    do_shift  = 1'b0;
    frame_rst = 1'b0;
    drop_n    = st_q.drop;
    mismatch  = 1'b0;
    new_byte  = {bit_v, st_q.shreg[7:1]};
    crc_n     = st_q.crc;

    // ========================================================================
    // Pin sampling: a level counts once the last two stages agree
    st_d.clk_sync = {st_q.clk_sync[1:0], link_clk_pin};
    st_d.dat_sync = {st_q.dat_sync[1:0], link_data_pin};
    if (st_q.clk_sync[2] == st_q.clk_sync[1]) begin
      st_d.clk_filt = st_q.clk_sync[2];
    end
    if (st_q.dat_sync[2] == st_q.dat_sync[1]) begin
      st_d.dat_filt = st_q.dat_sync[2];
    end
    bit_ev   = st_d.clk_filt & ~st_q.clk_filt;
    bit_v    = st_d.dat_filt;
    new_byte = {bit_v, st_q.shreg[7:1]};

    // ========================================================================
    // Bus write data phase
    st_d.dp_write = 1'b0;
    if (st_q.dp_write) begin
      unique case (st_q.dp_addr)
        hdlrx_pkg::REG_CFG: begin
          st_d.enable   = hwdata[hdlrx_pkg::CFG_EN];
          st_d.match_en = hwdata[hdlrx_pkg::CFG_MATCH];
        end
        hdlrx_pkg::REG_INTCTL: begin
          st_d.thresh = hwdata[hdlrx_pkg::INT_THR_MSB:hdlrx_pkg::INT_THR_LSB];
          st_d.irq_output_enable   = hwdata[hdlrx_pkg::INT_OE];
        end
        hdlrx_pkg::REG_ADDR: begin
          st_d.addrs = hwdata[23:0];
        end
        default: begin
        end
      endcase
    end

    // ========================================================================
    // Bus address phase; reads answer in the next cycle with zero waits.
    // Accesses are taken at bus speed; pacing them is left to the host
    if (hsel && hready && htrans[hdlrx_pkg::HTRANS_ACTIVE]) begin
      if (hwrite) begin
        st_d.dp_write = 1'b1;
        st_d.dp_addr  = haddr[7:0];
      end else begin
        st_d.rdata = '0;
        unique case (haddr[7:0])
          hdlrx_pkg::REG_CFG: begin
            st_d.rdata[hdlrx_pkg::CFG_EN]    = st_q.enable;
            st_d.rdata[hdlrx_pkg::CFG_MATCH] = st_q.match_en;
          end
          hdlrx_pkg::REG_INTCTL: begin
            st_d.rdata[hdlrx_pkg::INT_THR_MSB:hdlrx_pkg::INT_THR_LSB] = st_q.thresh;
            st_d.rdata[hdlrx_pkg::INT_OE] = st_q.irq_output_enable;
          end
          hdlrx_pkg::REG_STATUS: begin
            st_d.rdata[hdlrx_pkg::ST_EMPTY] = (st_q.count == hdlrx_pkg::FIFO_NONE);
            st_d.rdata[hdlrx_pkg::ST_PKT]   = st_q.pkt;
            st_d.rdata[hdlrx_pkg::ST_LINK_STATE_CHANGED]  = st_q.link_state_changed;
            st_d.rdata[hdlrx_pkg::ST_IRQ]   = irq_of(st_q);
            st_d.rdata[hdlrx_pkg::ST_OVR]   = st_q.fifo_overrun;
            st_d.rdata[hdlrx_pkg::ST_TAG_MSB:hdlrx_pkg::ST_TAG_LSB] = st_q.last_tag;
            st_d.rdata[hdlrx_pkg::ST_LINK_UP] = (st_q.link == hdlrx_pkg::LS_UP);
            // Read-to-clear; any set below in this cycle still wins
            st_d.pkt  = 1'b0;
            st_d.link_state_changed = 1'b0;
            st_d.fifo_overrun  = 1'b0;
          end
          hdlrx_pkg::REG_DATA: begin
            if (st_q.count != hdlrx_pkg::FIFO_NONE) begin
              st_d.rdata[7:0] = head.data;
              st_d.last_tag   = head.tag;
              pop             = 1'b1;
            end
          end
          hdlrx_pkg::REG_ADDR: begin
            st_d.rdata[23:0] = st_q.addrs;
          end
          default: begin
          end
        endcase
      end
    end

    // ========================================================================
    // Serial link
    if (!st_q.enable) begin
      // Held idle so that enabling starts a clean flag hunt
      st_d.link     = hdlrx_pkg::LS_DOWN;
      st_d.ones     = hdlrx_pkg::ONES_IDLE;
      frame_rst     = 1'b1;
      st_d.pkt      = 1'b0;
      st_d.link_state_changed     = 1'b0;
      st_d.fifo_overrun      = 1'b0;
      st_d.link_irq = 1'b0;
      st_d.fill_irq = 1'b0;
    end else if (bit_ev) begin
      if (bit_v) begin
        if (st_q.ones != hdlrx_pkg::ONES_IDLE) begin
          st_d.ones = st_q.ones + 3'h1;
        end
        if (st_q.ones == hdlrx_pkg::ONES_FLAG) begin
          // Seventh one in a row: abort
          frame_rst = 1'b1;
          if (st_q.link == hdlrx_pkg::LS_UP) begin
            push          = 1'b1;
            push_e        = '{data: hdlrx_pkg::DUMMY_BYTE, tag: hdlrx_pkg::TAG_ABORT};
            st_d.link     = hdlrx_pkg::LS_DOWN;
            st_d.link_state_changed     = 1'b1;
            st_d.link_irq = 1'b1;
          end
        end else if (st_q.link == hdlrx_pkg::LS_UP) begin
          do_shift = 1'b1;
        end
      end else begin
        st_d.ones = '0;
        if (st_q.ones == hdlrx_pkg::ONES_FLAG) begin
          frame_rst = 1'b1;
          if (st_q.link == hdlrx_pkg::LS_DOWN) begin
            push          = 1'b1;
            push_e        = '{data: hdlrx_pkg::DUMMY_BYTE, tag: hdlrx_pkg::TAG_LINKUP};
            st_d.link     = hdlrx_pkg::LS_UP;
            st_d.link_state_changed     = 1'b1;
            st_d.link_irq = 1'b1;
          end else if (st_q.hold_valid && !st_q.drop) begin
            // Closing flag: the held byte is the last one of the packet
            push        = 1'b1;
            push_e.data = st_q.hold;
            push_e.tag  = {hdlrx_pkg::TAG_EOP,
                           st_q.crc_byte != hdlrx_pkg::CRC_GOOD,
                           st_q.bitcnt != hdlrx_pkg::BIT_LAST};
            st_d.pkt    = 1'b1;
          end
        end else if (st_q.ones != hdlrx_pkg::ONES_STUFF &&
                     st_q.link == hdlrx_pkg::LS_UP) begin
          do_shift = 1'b1;
        end
      end
    end

    // Data bit: bits enter at the top so the first one ends up in bit zero
    if (do_shift) begin
      crc_n       = crc_step(st_q.crc, bit_v);
      st_d.crc    = crc_n;
      st_d.shreg  = new_byte;
      st_d.bitcnt = st_q.bitcnt + 3'h1;
      if (st_q.bitcnt == hdlrx_pkg::BIT_LAST) begin
        // Residue is checked at a byte boundary; in a byte-aligned frame the flag bits never reach it
        st_d.crc_byte = crc_n;
        st_d.first    = 1'b0;
        mismatch = (new_byte != st_q.addrs[hdlrx_pkg::ADDR_PRI_LSB +: 8]) &&
                   (new_byte != st_q.addrs[hdlrx_pkg::ADDR_SEC_LSB +: 8]) &&
                   (new_byte != st_q.addrs[hdlrx_pkg::ADDR_UNI_LSB +: 8]);
        drop_n = st_q.drop | (st_q.first & st_q.match_en & mismatch);
        st_d.drop = drop_n;
        if (!drop_n) begin
          // One byte is held back so the end tag can land on it
          if (st_q.hold_valid) begin
            push   = 1'b1;
            push_e = '{data: st_q.hold, tag: hdlrx_pkg::TAG_DATA};
          end
          st_d.hold       = new_byte;
          st_d.hold_valid = 1'b1;
        end
      end
    end

    if (frame_rst) begin
      st_d.bitcnt     = '0;
      st_d.crc        = hdlrx_pkg::CRC_INIT;
      st_d.hold_valid = 1'b0;
      st_d.first      = 1'b1;
      st_d.drop       = 1'b0;
    end

    // ========================================================================
    // FIFO pointers; push only ever happens while enabled
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + 7'h01;
    end
    if (push && !pop && st_q.count == hdlrx_pkg::FIFO_FULL) begin
      // Overrun discards everything held, including the frame in progress
      st_d.fifo_overrun    = 1'b1;
      st_d.wr_ptr = '0;
      st_d.rd_ptr = '0;
      st_d.count  = '0;
      if (st_d.hold_valid) begin
        st_d.drop       = 1'b1;
        st_d.hold_valid = 1'b0;
      end
    end else begin
      wr_en = push;
      if (push) begin
        st_d.wr_ptr = st_q.wr_ptr + 7'h01;
      end
      st_d.count = st_q.count + {7'h00, push} - {7'h00, pop};
    end

    // ========================================================================
    // Interrupt sources; a set always beats a clear
    if (st_d.count == hdlrx_pkg::FIFO_NONE) begin
      st_d.fill_irq = 1'b0;
      if (!push) begin
        st_d.link_irq = 1'b0;
      end
    end
    if (st_q.enable && st_d.count > {1'b0, st_q.thresh}) begin
      st_d.fill_irq = 1'b1;
    end

    st_d.hready   = 1'b1;
    st_d.irq_n    = ~irq_of(st_d);
    st_d.irq_oe_n = ~st_d.irq_output_enable;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= hdlrx_pkg::RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // Entries are only addressed below the pointers, so no reset is needed
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[st_q.wr_ptr] <= push_e;
    end
  end

  assign hreadyout    = st_q.hready;
  assign hresp        = 1'b0;
  assign hrdata       = st_q.rdata;
  assign irq_pin_n    = st_q.irq_n;
  assign irq_pin_oe_n = st_q.irq_oe_n;

endmodule : hdlrx_link_receiver

// >>> verilog/hdlrx_pkg.sv
package hdlrx_pkg;

  // ==========================================================================
  // FIFO geometry
  localparam int unsigned     FIFO_DEPTH = 128;
  localparam int unsigned     FIFO_AW    = 7;
  localparam logic [7:0]      FIFO_FULL  = 8'h80;
  localparam logic [7:0]      FIFO_NONE  = 8'h00;

  // ==========================================================================
  // Register byte offsets, decoded from haddr[7:0]
  localparam logic [7:0]      REG_CFG    = 8'h00;
  localparam logic [7:0]      REG_INTCTL = 8'h04;
  localparam logic [7:0]      REG_STATUS = 8'h08;
  localparam logic [7:0]      REG_DATA   = 8'h0C;
  localparam logic [7:0]      REG_ADDR   = 8'h10;

  // Field positions
  localparam int unsigned     CFG_EN        = 0;
  localparam int unsigned     CFG_MATCH     = 1;
  localparam int unsigned     INT_THR_LSB   = 0;
  localparam int unsigned     INT_THR_MSB   = 6;
  localparam int unsigned     INT_OE        = 7;
  localparam int unsigned     ST_EMPTY      = 0;
  localparam int unsigned     ST_PKT        = 1;
  localparam int unsigned     ST_LINK_STATE_CHANGED       = 2;
  localparam int unsigned     ST_IRQ        = 3;
  localparam int unsigned     ST_OVR        = 4;
  localparam int unsigned     ST_TAG_LSB    = 5;
  localparam int unsigned     ST_TAG_MSB    = 7;
  localparam int unsigned     ST_LINK_UP    = 8;
  localparam int unsigned     ADDR_PRI_LSB  = 0;
  localparam int unsigned     ADDR_SEC_LSB  = 8;
  localparam int unsigned     ADDR_UNI_LSB  = 16;
  localparam int unsigned     HTRANS_ACTIVE = 1;

  // ==========================================================================
  // Byte tags and line codes
  localparam logic [2:0]      TAG_DATA   = 3'b000;
  localparam logic [2:0]      TAG_LINKUP = 3'b001;
  localparam logic [2:0]      TAG_ABORT  = 3'b010;
  localparam logic            TAG_EOP    = 1'b1;
  localparam logic [7:0]      DUMMY_BYTE = 8'h00;
  localparam logic [2:0]      ONES_IDLE  = 3'h7;
  localparam logic [2:0]      ONES_FLAG  = 3'h6;
  localparam logic [2:0]      ONES_STUFF = 3'h5;
  localparam logic [2:0]      BIT_LAST   = 3'h7;
  localparam logic [15:0]     CRC_INIT   = 16'hFFFF;
  localparam logic [15:0]     CRC_POLY   = 16'h8408;
  localparam logic [15:0]     CRC_GOOD   = 16'hF0B8;

  typedef enum logic [1:0] {
    LS_DOWN = 2'b01,
    LS_UP   = 2'b10
  } hdlrx_link_e;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] tag;
  } hdlrx_entry_s;

  typedef struct packed {
    hdlrx_link_e       link;
    logic              enable;
    logic              match_en;
    logic              irq_output_enable;
    logic [6:0]        thresh;
    logic [23:0]       addrs;
    logic [2:0]        clk_sync;
    logic [2:0]        dat_sync;
    logic              clk_filt;
    logic              dat_filt;
    logic [2:0]        ones;
    logic [7:0]        shreg;
    logic [2:0]        bitcnt;
    logic [15:0]       crc;
    logic [15:0]       crc_byte;
    logic [7:0]        hold;
    logic              hold_valid;
    logic              first;
    logic              drop;
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic [7:0]        count;
    logic [2:0]        last_tag;
    logic              pkt;
    logic              link_state_changed;
    logic              fifo_overrun;
    logic              link_irq;
    logic              fill_irq;
    logic              dp_write;
    logic [7:0]        dp_addr;
    logic [31:0]       rdata;
    logic              hready;
    logic              irq_n;
    logic              irq_oe_n;
  } hdlrx_state_s;

  localparam hdlrx_state_s RST_STATE = '{
    link:     LS_DOWN,
    ones:     ONES_IDLE,
    crc:      CRC_INIT,
    crc_byte: CRC_INIT,
    first:    1'b1,
    hready:   1'b1,
    irq_n:    1'b1,
    irq_oe_n: 1'b1,
    default:  '0
  };

endpackage : hdlrx_pkg
